/* src/mtc_pkg.sv */
// Purpose: shared constants and types for the measurement trigger control block
// Assumes: 200 MHz REF_CLK, plain register port with 8-bit byte addresses
// Notes: limits are signed counts; scale follows the active range outside
package mtc_pkg;

    localparam int CLK_MHZ = 200;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STORAGE_INTERVAL = 8'h04;
    localparam logic [7:0] OFS_STORE_BUFFER_SIZE = 8'h08;
    localparam logic [7:0] OFS_LIMIT_LO = 8'h0C;
    localparam logic [7:0] OFS_LIMIT_HI = 8'h10;
    localparam logic [7:0] OFS_PROG = 8'h14;
    localparam logic [7:0] OFS_SETUP = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_ERROR = 8'h20;
    localparam logic [7:0] OFS_REMOTE = 8'h24;
    localparam logic [7:0] OFS_READING = 8'h28;

    // field positions
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_ONE_BIT = 1;
    localparam int CTRL_STORE_BIT = 2;
    localparam int SETUP_FREQ_BIT = 5;
    localparam int REMOTE_SAVE_BIT = 0;
    localparam int REMOTE_SRQ_CLR_BIT = 1;

    // front panel program numbers
    localparam logic [5:0] PROG_SAVE = 6'h1E;
    localparam logic [5:0] PROG_LIMITS = 6'h23;
    localparam logic [5:0] PROG_CAL = 6'h24;
    localparam logic [5:0] PROG_RESET = 6'h25;
    localparam logic [5:0] PROG_INIT = 6'h26;

    // 3029999 counts
    localparam logic signed [31:0] LIMIT_MAX = 32'sh002E3BEF;
    // error 260
    localparam logic [15:0] ERR_CAL_LOCKED = 16'h0104;

    // timing
    localparam int RC_PULSE_NS = 1000;
    localparam logic [15:0] RC_PULSE_CYC = 16'((RC_PULSE_NS * CLK_MHZ + 999) / 1000);
    localparam int CONV_PERIOD_US = 100;

    typedef struct packed {
        logic ext_src;
        logic one_shot;
        logic store_en;
        logic [15:0] storage_interval;
        logic [15:0] store_buffer_size;
        logic signed [31:0] lim_lo;
        logic signed [31:0] lim_hi;
        logic [4:0] bus_addr;
        logic line_50hz;
    } mtc_settings_t;

    localparam mtc_settings_t FACTORY = '{
        ext_src: 1'b0,
        one_shot: 1'b0,
        store_en: 1'b0,
        storage_interval: 16'h0000,
        store_buffer_size: 16'h0100,
        lim_lo: -LIMIT_MAX,
        lim_hi: LIMIT_MAX,
        bus_addr: 5'h10,
        line_50hz: 1'b0
    };

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic we;
        logic re;
    } mtc_bus_req_t;

    typedef struct packed {
        logic stb;
        logic enter;
        logic signed [31:0] value;
    } mtc_key_t;

    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [31:0] data;
    } mtc_store_wr_t;

    typedef enum logic [0:0] {T_IDLE, T_CONV} mtc_trig_st_t;
    typedef enum logic [1:0] {P_IDLE, P_LO, P_HI, P_CONFIRM} mtc_prog_st_t;
    typedef enum logic [1:0] {A_SAVE, A_RESET, A_INIT} mtc_action_t;

endpackage

/* src/mtc_top.sv */
// Purpose: reading trigger, data store feed, reading-complete pulse and front panel programs
// Assumes: conversion engine outside answers CONV_START with CONV_DONE; keys come from the same clock
// Notes: power-up settings live in flip-flops, so a save lasts until RST_N
`timescale 1ns/1ps
module mtc_top #(
    parameter int CONV_PERIOD_CYC = mtc_pkg::CONV_PERIOD_US * mtc_pkg::CLK_MHZ
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire mtc_pkg::mtc_bus_req_t BUS_REQ,
    output logic [31:0] BUS_RDATA,
    input wire logic EXT_TRIG_N,
    input wire logic CAL_LOCK,
    input wire mtc_pkg::mtc_key_t KEY,
    output logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [31:0] CONV_DATA,
    output mtc_pkg::mtc_store_wr_t STORE_WR,
    output logic RDG_CMPL_N,
    output logic PON_SRQ
);
    import mtc_pkg::*;

    typedef struct packed {
        mtc_settings_t cur;
        mtc_settings_t pon;
        logic [2:0] trig_sync;
        logic trig_lvl;
        logic [2:0] lock_sync;
        logic lock_lvl;
        mtc_trig_st_t tst;
        mtc_prog_st_t pst;
        mtc_action_t act;
        logic pend;
        logic run;
        logic [31:0] pace;
        logic [15:0] rc_cnt;
        logic rc_low;
        logic storing;
        logic [15:0] skip;
        logic [15:0] scount;
        logic [31:0] reading;
        logic cal_active;
        logic [15:0] err;
        logic srq;
        logic [31:0] rdata;
        logic conv_start;
        mtc_store_wr_t store;
    } mtc_state_t;

    mtc_state_t q;
    mtc_state_t d;

    // limits are judged in counts; scaling to the active range happens outside
    function automatic logic in_range(input logic signed [31:0] v);
        in_range = (v <= LIMIT_MAX) && (v >= -LIMIT_MAX);
    endfunction

    function automatic logic [31:0] read_mux(input mtc_state_t s, input logic [7:0] a);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == OFS_CTRL) begin
            r[CTRL_EXT_BIT] = s.cur.ext_src;
            r[CTRL_ONE_BIT] = s.cur.one_shot;
            r[CTRL_STORE_BIT] = s.cur.store_en;
        end else if (a == OFS_STORAGE_INTERVAL) begin
            r[15:0] = s.cur.storage_interval;
        end else if (a == OFS_STORE_BUFFER_SIZE) begin
            r[15:0] = s.cur.store_buffer_size;
        end else if (a == OFS_LIMIT_LO) begin
            r = s.cur.lim_lo;
        end else if (a == OFS_LIMIT_HI) begin
            r = s.cur.lim_hi;
        end else if (a == OFS_SETUP) begin
            r[4:0] = s.cur.bus_addr;
            r[SETUP_FREQ_BIT] = s.cur.line_50hz;
        end else if (a == OFS_STATUS) begin
            r[0] = (s.tst == T_CONV);
            r[1] = s.run;
            r[2] = s.pend;
            r[3] = s.storing;
            r[4] = s.cal_active;
            r[5] = s.srq;
            r[6] = (s.pst != P_IDLE);
            r[7] = s.lock_lvl;
            r[31:16] = s.scount;
        end else if (a == OFS_ERROR) begin
            r[15:0] = s.err;
        end else if (a == OFS_READING) begin
            r = s.reading;
        end
        return r;
    endfunction

    logic trig_fall;
    logic enter_key;
    logic trig_evt;
    logic oneshot_mode;
    logic running;
    logic do_store;

    always_comb begin
        d = q;
        d.conv_start = 1'b0;
        d.store.we = 1'b0;
        d.rdata = 32'h0000_0000;
        do_store = 1'b0;

        // pin synchronisers: a level counts once stages two and three agree
        d.trig_sync = {q.trig_sync[1:0], EXT_TRIG_N};
        d.lock_sync = {q.lock_sync[1:0], CAL_LOCK};
        if (q.trig_sync[1] == q.trig_sync[2]) begin
            d.trig_lvl = q.trig_sync[2];
        end
        if (q.lock_sync[1] == q.lock_sync[2]) begin
            d.lock_lvl = q.lock_sync[2];
        end
        trig_fall = q.trig_lvl && (q.trig_sync[1] == q.trig_sync[2]) && !q.trig_sync[2];

        enter_key = KEY.stb && KEY.enter && (q.pst == P_IDLE);
        trig_evt = q.cur.ext_src && (trig_fall || enter_key);
        oneshot_mode = q.cur.ext_src && q.cur.one_shot;
        running = !q.cur.ext_src || q.run;

        // register writes
        if (BUS_REQ.we) begin
            if (BUS_REQ.addr == OFS_CTRL) begin
                d.cur.ext_src = BUS_REQ.wdata[CTRL_EXT_BIT];
                d.cur.one_shot = BUS_REQ.wdata[CTRL_ONE_BIT];
                d.cur.store_en = BUS_REQ.wdata[CTRL_STORE_BIT];
                d.run = 1'b0;
                d.pend = 1'b0;
                d.storing = 1'b0;
            end else if (BUS_REQ.addr == OFS_STORAGE_INTERVAL) begin
                d.cur.storage_interval = BUS_REQ.wdata[15:0];
            end else if (BUS_REQ.addr == OFS_STORE_BUFFER_SIZE) begin
                d.cur.store_buffer_size = BUS_REQ.wdata[15:0];
                d.scount = 16'h0000;
                d.storing = 1'b0;
            end else if (BUS_REQ.addr == OFS_SETUP) begin
                d.cur.bus_addr = BUS_REQ.wdata[4:0];
                d.cur.line_50hz = BUS_REQ.wdata[SETUP_FREQ_BIT];
            end else if (BUS_REQ.addr == OFS_ERROR) begin
                d.err = 16'h0000;
            end else if (BUS_REQ.addr == OFS_REMOTE) begin
                if (BUS_REQ.wdata[REMOTE_SAVE_BIT]) begin
                    d.pon = q.cur;
                end
                if (BUS_REQ.wdata[REMOTE_SRQ_CLR_BIT]) begin
                    d.srq = 1'b0;
                end
            // a program number written while another program is open is dropped
            end else if (BUS_REQ.addr == OFS_PROG && q.pst == P_IDLE) begin
                d.cal_active = 1'b0;
                case (BUS_REQ.wdata[5:0])
                    PROG_LIMITS: begin
                        d.pst = P_LO;
                    end
                    PROG_CAL: begin
                        if (q.lock_lvl) begin
                            d.cal_active = 1'b1;
                        end else begin
                            d.err = ERR_CAL_LOCKED;
                        end
                    end
                    PROG_SAVE: begin
                        d.pst = P_CONFIRM;
                        d.act = A_SAVE;
                    end
                    PROG_RESET: begin
                        d.pst = P_CONFIRM;
                        d.act = A_RESET;
                    end
                    PROG_INIT: begin
                        d.pst = P_CONFIRM;
                        d.act = A_INIT;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // front panel programs
        case (q.pst)
            P_LO: begin
                if (KEY.stb && KEY.enter) begin
                    d.cur.lim_lo = in_range(KEY.value) ? KEY.value : q.pon.lim_lo;
                    d.pst = P_HI;
                end
            end
            P_HI: begin
                if (KEY.stb && KEY.enter) begin
                    d.cur.lim_hi = in_range(KEY.value) ? KEY.value : q.pon.lim_hi;
                    d.pst = P_IDLE;
                end
            end
            P_CONFIRM: begin
                if (KEY.stb) begin
                    d.pst = P_IDLE;
                    if (KEY.enter) begin
                        case (q.act)
                            A_SAVE: begin
                                d.pon = q.cur;
                            end
                            A_RESET: begin
                                // factory settings, keeping the current bus address and line frequency, also become the power-on state for a later init
                                d.cur = FACTORY;
                                d.cur.bus_addr = q.cur.bus_addr;
                                d.cur.line_50hz = q.cur.line_50hz;
                                d.pon = d.cur;
                                d.run = 1'b0;
                                d.pend = 1'b0;
                                d.storing = 1'b0;
                            end
                            default: begin
                                d.cur = q.pon;
                                d.run = 1'b0;
                                d.pend = 1'b0;
                                d.storing = 1'b0;
                            end
                        endcase
                    end
                end
            end
            default: begin
            end
        endcase

        // conversion pacing
        // the pace counter runs on through a conversion so the rate does not stretch with its length
        if (q.pace != 32'h0000_0000) begin
            d.pace = q.pace - 32'h0000_0001;
        end

        case (q.tst)
            T_IDLE: begin
                if (oneshot_mode ? q.pend : (running && q.pace == 32'h0000_0000)) begin
                    d.conv_start = 1'b1;
                    d.pend = 1'b0;
                    d.pace = 32'(CONV_PERIOD_CYC - 1);
                    d.tst = T_CONV;
                end
            end
            default: begin
                if (CONV_DONE) begin
                    d.reading = CONV_DATA;
                    d.rc_cnt = RC_PULSE_CYC;
                    d.tst = T_IDLE;
                    if (q.cur.store_en && q.scount < q.cur.store_buffer_size) begin
                        if (oneshot_mode) begin
                            do_store = 1'b1;
                        end else if (q.storing) begin
                            if (q.skip == q.cur.storage_interval) begin
                                do_store = 1'b1;
                                d.skip = 16'h0000;
                            end else begin
                                d.skip = q.skip + 16'h0001;
                            end
                        end
                    end
                end
            end
        endcase

        if (do_store) begin
            d.store.we = 1'b1;
            d.store.addr = q.scount;
            d.store.data = CONV_DATA;
            d.scount = q.scount + 16'h0001;
            if (q.scount + 16'h0001 == q.cur.store_buffer_size) begin
                d.storing = 1'b0;
            end
        end

        // trigger events last, so a set wins over a clear in the same cycle
        if (trig_evt) begin
            if (q.cur.one_shot) begin
                d.pend = 1'b1;
            end else begin
                d.run = 1'b1;
                if (q.cur.store_en && !q.storing) begin
                    d.storing = 1'b1;
                    d.skip = q.cur.storage_interval;
                end
            end
        end

        // reading-complete pulse
        // a done inside a running pulse restarts it, so readings closer than the pulse merge
        if (q.rc_cnt != 16'h0000 && !(q.tst == T_CONV && CONV_DONE)) begin
            d.rc_cnt = q.rc_cnt - 16'h0001;
        end
        d.rc_low = (d.rc_cnt != 16'h0000);

        if (BUS_REQ.re) begin
            d.rdata = read_mux(q, BUS_REQ.addr);
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            q <= '0;
            q.cur <= FACTORY;
            q.pon <= FACTORY;
            q.trig_sync <= 3'h7;
            q.trig_lvl <= 1'b1;
            q.srq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign BUS_RDATA = q.rdata;
    assign CONV_START = q.conv_start;
    assign STORE_WR = q.store;
    assign RDG_CMPL_N = ~q.rc_low;
    assign PON_SRQ = q.srq;

endmodule // mtc_top

/* verification/mtc_chk.sv */
// Purpose: port checks for trigger, conversion and reading-complete timing
// Assumes: sees only mtc_top ports
// Notes: one-shot mode is followed from control register writes
`timescale 1ns/1ps
module mtc_chk #(
    parameter int CONV_PERIOD_CYC = 20000
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire mtc_pkg::mtc_bus_req_t BUS_REQ,
    input wire logic [31:0] BUS_RDATA,
    input wire logic EXT_TRIG_N,
    input wire logic CAL_LOCK,
    input wire mtc_pkg::mtc_key_t KEY,
    input wire logic CONV_START,
    input wire logic CONV_DONE,
    input wire logic [31:0] CONV_DATA,
    input wire mtc_pkg::mtc_store_wr_t STORE_WR,
    input wire logic RDG_CMPL_N,
    input wire logic PON_SRQ
);
    import mtc_pkg::*;
    logic open_q;
    logic one_q;
    logic [15:0] low_q;
    logic [31:0] gap_q;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            open_q <= 1'b0;
            one_q <= 1'b0;
            low_q <= 16'h0;
            gap_q <= 32'hFFFF_FFFF;
        end else begin
            open_q <= CONV_START || (open_q && !CONV_DONE);
            if (BUS_REQ.we && BUS_REQ.addr == OFS_CTRL) begin
                one_q <= BUS_REQ.wdata[CTRL_EXT_BIT] && BUS_REQ.wdata[CTRL_ONE_BIT];
            end
            low_q <= RDG_CMPL_N ? 16'h0 : ((low_q == 16'hFFFF) ? low_q : low_q + 16'h1);
            gap_q <= CONV_START ? 32'h1 : ((gap_q == 32'hFFFF_FFFF) ? gap_q : gap_q + 32'h1);
        end
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_first_conv: assert property ($rose(RST_N) |-> ##[0:2] CONV_START)
        else $error("no conversion after reset");
    a_trig_start: assert property (one_q && !open_q && !CONV_START && $fell(EXT_TRIG_N) |-> ##[2:6] CONV_START)
        else $error("trigger edge not followed by a conversion");
    a_start_pulse: assert property (CONV_START |=> !CONV_START)
        else $error("start longer than one cycle");
    a_start_closed: assert property (open_q |-> !CONV_START)
        else $error("start while a conversion is open");
    a_rc_after_done: assert property (open_q && CONV_DONE |=> !RDG_CMPL_N)
        else $error("no reading-complete after done");
    a_rc_cause: assert property ($fell(RDG_CMPL_N) |-> $past(CONV_DONE && open_q))
        else $error("reading-complete without a finished reading");
    a_rc_width: assert property ($rose(RDG_CMPL_N) |-> low_q >= RC_PULSE_CYC)
        else $error("reading-complete pulse too short");
    a_store_cause: assert property (STORE_WR.we |-> $past(CONV_DONE && open_q))
        else $error("store write without a finished reading");
    a_start_spacing: assert property (CONV_START && !one_q |-> gap_q >= CONV_PERIOD_CYC)
        else $error("continuous start before the conversion period");
    a_srq_no_rise: assert property (!$rose(PON_SRQ))
        else $error("power-on request raised");
    c_done: cover property (open_q && CONV_DONE);
    c_rc_end: cover property ($rose(RDG_CMPL_N));
    c_store: cover property (STORE_WR.we);
endmodule // mtc_chk

/* verification/mtc_partner.sv */
// Purpose: converter and external trigger source beside mtc_top
// Assumes: lat sets the conversion time in cycles
// Notes: data line shows the inverse of its last value outside done
`timescale 1ns/1ps
module mtc_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] lat,
    input wire logic fire,
    input wire logic stray,
    input wire logic conv_start,
    output logic conv_done,
    output logic [31:0] conv_data,
    output logic ext_trig_n
);
    logic busy;
    logic [7:0] cnt;
    logic [3:0] low;
    logic [31:0] val;
    initial begin
        conv_done = 1'b0;
        conv_data = 32'h0;
        ext_trig_n = 1'b1;
        busy = 1'b0;
        cnt = 8'h0;
        low = 4'h0;
        val = 32'h10000001;
    end
    // pulled-up pin: one clean falling edge, then held low nine cycles
    always @(posedge clk) begin
        low <= fire ? 4'h8 : ((low != 4'h0) ? low - 4'h1 : low);
        ext_trig_n <= (low == 4'h0) && !fire;
    end
    always @(posedge clk) begin
        conv_done <= stray;
        conv_data <= stray ? val : ~conv_data;
        if (!rst_n) begin
            busy <= 1'b0;
        end else if (busy && cnt == 8'h0) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= val;
            val <= val + 32'h00000011;
        end else if (busy) begin
            cnt <= cnt - 8'h1;
        end else if (conv_start) begin
            busy <= 1'b1;
            cnt <= lat;
        end
    end
endmodule // mtc_partner

/* verification/tb_mtc_top.sv */
// Purpose: self-checking bench for mtc_top
// Assumes: conversion period shortened to 250 cycles
// Notes: monitors count starts, readings, pulses and stores
`timescale 1ns/1ps
module tb_mtc_top;
    import mtc_pkg::*;
    localparam int PER = 250;
    logic ref_clk;
    logic rst_n;
    mtc_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    logic ext_trig_n;
    logic cal_lock;
    mtc_key_t key;
    logic conv_start;
    logic conv_done;
    logic [31:0] conv_data;
    mtc_store_wr_t store_wr;
    logic rdg_cmpl_n;
    logic pon_srq;
    logic [7:0] lat;
    logic fire;
    logic stray;
    logic open_q;
    logic rc_q;
    logic [31:0] last_q;
    logic [31:0] rd_q;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_start = 0;
    int n_rc = 0;
    int n_st = 0;
    int s0;
    int r0;
    int t0;
    int a0 = -1;

    mtc_top #(.CONV_PERIOD_CYC(PER)) mtc_top_i (.REF_CLK(ref_clk), .RST_N(rst_n), .BUS_REQ(bus_req),
        .BUS_RDATA(bus_rdata), .EXT_TRIG_N(ext_trig_n), .CAL_LOCK(cal_lock), .KEY(key),
        .CONV_START(conv_start), .CONV_DONE(conv_done), .CONV_DATA(conv_data), .STORE_WR(store_wr),
        .RDG_CMPL_N(rdg_cmpl_n), .PON_SRQ(pon_srq));
    mtc_partner mtc_partner_i (.clk(ref_clk), .rst_n(rst_n), .lat(lat), .fire(fire), .stray(stray),
        .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data), .ext_trig_n(ext_trig_n));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req.re <= 1'b0;
        @(negedge ref_clk);
        rd_q = bus_rdata;
    endtask
    task automatic press(input logic e, input logic [31:0] v);
        @(posedge ref_clk);
        key <= '{1'b1, e, v};
        @(posedge ref_clk);
        key.stb <= 1'b0;
        idle(2);
    endtask
    task automatic pulse(input logic s);
        @(posedge ref_clk);
        fire <= !s;
        stray <= s;
        @(posedge ref_clk);
        fire <= 1'b0;
        stray <= 1'b0;
    endtask
    task automatic snap();
        s0 = n_start;
        r0 = n_rc;
        t0 = n_st;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        rc_q <= rdg_cmpl_n;
        open_q <= rst_n && (conv_start || (open_q && !conv_done));
        if (conv_start) n_start++;
        if (open_q && conv_done) last_q <= conv_data;
        if (rc_q && !rdg_cmpl_n) n_rc++;
        if (store_wr.we) begin
            n_st++;
            chk(store_wr.data, last_q);
            if (a0 >= 0) chk(32'(store_wr.addr), 32'(n_st - 1 - a0));
        end
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic t_power_up();
        rd(OFS_LIMIT_LO);
        chk(rd_q, -LIMIT_MAX);
        rd(OFS_LIMIT_HI);
        chk(rd_q, LIMIT_MAX);
        rd(OFS_CTRL);
        chk(rd_q, 32'h0);
        chk(32'(pon_srq), 32'h1);
        rd(8'h3C);
        chk(rd_q, 32'h0);
        snap();
        idle(4 * PER);
        chk(32'(n_start - s0 inside {[3:5]}), 32'h1);
        chk(32'(n_rc - r0 inside {[3:5]}), 32'h1);
    endtask
    task automatic t_one_shot();
        wr(OFS_CTRL, 32'h7);
        idle(300);
        snap();
        repeat (3) begin
            pulse(1'b0);
            idle(300);
        end
        pulse(1'b1);
        idle(300);
        chk(32'(n_start - s0), 32'h3);
        chk(32'(n_rc - r0), 32'h3);
        chk(32'(n_st - t0), 32'h3);
        lat <= 8'd100;
        snap();
        repeat (3) begin
            pulse(1'b0);
            idle(20);
        end
        idle(500);
        chk(32'(n_start - s0), 32'h2);
        lat <= 8'd5;
    endtask
    task automatic t_key_store();
        snap();
        press(1'b0, 32'h0);
        idle(300);
        press(1'b1, 32'h0);
        idle(300);
        press(1'b1, 32'h0);
        idle(300);
        chk(32'(n_st - t0), 32'h2);
        rd(OFS_READING);
        chk(rd_q, last_q);
    endtask
    task automatic t_ext_cont();
        wr(OFS_STORE_BUFFER_SIZE, 32'h3);
        wr(OFS_STORAGE_INTERVAL, 32'h1);
        a0 = n_st;
        wr(OFS_CTRL, 32'h5);
        idle(300);
        snap();
        idle(600);
        chk(32'(n_start - s0), 32'h0);
        press(1'b1, 32'h0);
        idle(6 * PER);
        chk(32'(n_st - t0), 32'h3);
        rd(OFS_STATUS);
        chk(32'(rd_q[31:16]), 32'h3);
        chk(32'(rd_q[3]), 32'h0);
        chk(32'(n_start - s0 > 4), 32'h1);
    endtask
    task automatic t_limits();
        wr(OFS_REMOTE, 32'h2);
        idle(2);
        wr(OFS_PROG, 32'(PROG_LIMITS));
        press(1'b1, -32'sd100);
        press(1'b0, 32'h7);
        press(1'b1, 32'sd500);
        rd(OFS_LIMIT_LO);
        chk(rd_q, -32'sd100);
        rd(OFS_LIMIT_HI);
        chk(rd_q, 32'sd500);
        wr(OFS_PROG, 32'(PROG_SAVE));
        press(1'b1, 32'h0);
        wr(OFS_PROG, 32'(PROG_LIMITS));
        press(1'b1, -LIMIT_MAX - 32'sd1);
        press(1'b1, 32'sd900);
        rd(OFS_LIMIT_LO);
        chk(rd_q, -32'sd100);
        wr(OFS_PROG, 32'(PROG_INIT));
        press(1'b1, 32'h0);
        rd(OFS_LIMIT_HI);
        chk(rd_q, 32'sd500);
        chk(32'(pon_srq), 32'h0);
    endtask
    task automatic t_reset_prog();
        wr(OFS_SETUP, 32'h25);
        wr(OFS_PROG, 32'(PROG_RESET));
        press(1'b0, 32'h0);
        rd(OFS_LIMIT_HI);
        chk(rd_q, 32'sd500);
        wr(OFS_PROG, 32'(PROG_RESET));
        press(1'b1, 32'h0);
        rd(OFS_LIMIT_LO);
        chk(rd_q, -LIMIT_MAX);
        rd(OFS_SETUP);
        chk(rd_q, 32'h25);
        wr(OFS_SETUP, 32'h0A);
        wr(OFS_REMOTE, 32'h1);
        wr(OFS_SETUP, 32'h11);
        wr(OFS_PROG, 32'(PROG_INIT));
        press(1'b1, 32'h0);
        rd(OFS_SETUP);
        chk(rd_q, 32'h0A);
    endtask
    task automatic t_cal();
        wr(OFS_PROG, 32'(PROG_CAL));
        rd(OFS_ERROR);
        chk(rd_q, 32'(ERR_CAL_LOCKED));
        wr(OFS_ERROR, 32'h0);
        cal_lock <= 1'b1;
        idle(6);
        wr(OFS_PROG, 32'(PROG_CAL));
        rd(OFS_ERROR);
        chk(rd_q, 32'h0);
        rd(OFS_STATUS);
        chk(32'(rd_q[4]), 32'h1);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        key = '0;
        cal_lock = 1'b0;
        lat = 8'd5;
        fire = 1'b0;
        stray = 1'b0;
        open_q = 1'b0;
        rc_q = 1'b1;
        last_q = 32'h0;
        idle(4);
        rst_n <= 1'b1;
        t_power_up();
        t_one_shot();
        t_key_store();
        t_ext_cont();
        t_limits();
        t_reset_prog();
        t_cal();
        print_verdict();
    end
endmodule // tb_mtc_top

bind mtc_top mtc_chk #(.CONV_PERIOD_CYC(CONV_PERIOD_CYC)) mtc_chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .BUS_REQ(BUS_REQ), .BUS_RDATA(BUS_RDATA), .EXT_TRIG_N(EXT_TRIG_N), .CAL_LOCK(CAL_LOCK), .KEY(KEY),
    .CONV_START(CONV_START), .CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .STORE_WR(STORE_WR),
    .RDG_CMPL_N(RDG_CMPL_N), .PON_SRQ(PON_SRQ));
